// >>> pmcrb_cfg.svh
/*
  Register offsets, field positions, reset values and fixed codes for the
  control register bank. Assumes inclusion by the bank and its package users.
*/
`ifndef PMCRB_CFG_SVH
`define PMCRB_CFG_SVH

// Register offsets
`define PMCRB_OFS_PART_ID 8'h00
`define PMCRB_OFS_NVM_VER 8'h01
`define PMCRB_OFS_BUCK0_CTRL 8'h02
`define PMCRB_OFS_PG_CFG_A 8'h15
`define PMCRB_OFS_PG_CFG_B 8'h16
`define PMCRB_OFS_POWER_GOOD_FAULT_FLAGS 8'h17
`define PMCRB_OFS_SOFT_RESET 8'h18
`define PMCRB_OFS_INT_TOP_A 8'h19
`define PMCRB_OFS_INT_TOP_B 8'h1A
`define PMCRB_OFS_INT_SW 8'h1B
`define PMCRB_OFS_INT_LIN 8'h1C
`define PMCRB_OFS_STAT_TOP 8'h1D
`define PMCRB_OFS_STAT_SW 8'h1E
`define PMCRB_OFS_STAT_LIN 8'h1F
`define PMCRB_OFS_MASK_TOP_A 8'h20
`define PMCRB_OFS_MASK_TOP_B 8'h21
`define PMCRB_OFS_MASK_SW 8'h22
`define PMCRB_OFS_MASK_LIN 8'h23
`define PMCRB_OFS_LOAD_SEL 8'h24
`define PMCRB_OFS_LOAD_HIGH 8'h25
`define PMCRB_OFS_LOAD_LOW 8'h26

// First buck control field positions
`define PMCRB_BIT_MULTIPHASE 4
`define PMCRB_BIT_FPWM 3
`define PMCRB_BIT_DISCHARGE 2
`define PMCRB_BIT_PIN_GATE 1
`define PMCRB_BIT_ENABLE 0
`define PMCRB_BUCK0_WMASK 8'h1F

// Reset values
`define PMCRB_RST_BUCK0_CTRL 8'h04
`define PMCRB_RST_ZERO 8'h00

// Identification: part id field sits in bits 7:6, low six bits fixed
`define PMCRB_PART_ID_LSB 6
`define PMCRB_PART_ID_LOW 6'h00
`define PMCRB_RD_ZERO 8'h00

`endif

// >>> pmcrb_pkg.sv
/*
  Types shared by the control register bank.
  Assumes the constants header is included where offsets are needed.
*/
package pmcrb_pkg;
  typedef logic [7:0] pmcrb_byte_t;
  typedef logic [1:0] pmcrb_part_t;
endpackage

// >>> pmcrb_regbank.sv
/*
  Control and status register bank of a dual buck, dual linear regulator
  power manager. Byte registers are reached through a simple byte port fed
  by the serial front end (write strobe, read strobe, address, data).
  Register map, offset then name:
    0x00 part_identification, read only
    0x01 nvm_version_code, read only
    0x02 first_buck_control, read and write
    0x15 power_good_config_a, read and write
    0x16 power_good_config_b, read and write
    0x17 power_good_fault_flags, read only
    0x18 soft_reset_control, self-clearing, reads zero
    0x19 top_interrupt_flags_a, write one to clear
    0x1A top_interrupt_flags_b, write one to clear
    0x1B switcher_interrupt_flags, write one to clear
    0x1C linear_interrupt_flags, write one to clear
    0x1D top_level_state, read only
    0x1E switcher_state, read only
    0x1F linear_state, read only
    0x20 top_interrupt_mask_a, read and write
    0x21 top_interrupt_mask_b, read and write
    0x22 switcher_interrupt_mask, read and write
    0x23 linear_interrupt_mask, read and write
    0x24 load_measure_select, read and write
    0x25 load_current_high, read only
    0x26 load_current_low, read only
  Unmapped offsets read zero and ignore writes.
  Assumes the serial front end is synchronous to i_sys_clk and that the
  analog side supplies status, fault and event inputs synchronously.
  Assumes i_en_pin is already synchronous to i_sys_clk.
  Assumes the host writes reserved bits as zero and never relies on them.
*/
// Functional notes
// - Control bit 4: 0 automatic phase add and shed, 1 forced two-phase.
// - Control bit 3: 0 automatic PFM/PWM switching, 1 always PWM.
// - Control bit 2 defaults set; connects discharge resistor while regulator disabled.
// - Control bit 1: 0 register bit alone, 1 register bit and pin together.
// - Control bit 0 enables the first buck, subject to pin gating.
// - Offset zero shows read-only two-bit variant id in bits 7:6.
// - Offset one shows read-only eight-bit configuration memory version code.
`timescale 1ns/1ps
`include "pmcrb_cfg.svh"

module pmcrb_regbank
  import pmcrb_pkg::*;
#(
  parameter pmcrb_part_t PART_ID = 2'h1, // Arbitrary variant code
  parameter pmcrb_byte_t NVM_VERSION = 8'h5A // Arbitrary memory version code
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  // Byte register port from the serial front end
  input wire logic i_wr_stb,
  input wire logic i_rd_stb,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  // Regulator side levels and events
  input wire logic i_en_pin,
  input wire logic [3:0] i_power_good_fault_flags,
  input wire logic [7:0] i_top_stat,
  input wire logic [7:0] i_sw_stat,
  input wire logic [7:0] i_lin_stat,
  input wire logic [7:0] i_top_evt,
  input wire logic [7:0] i_sw_evt,
  input wire logic [7:0] i_lin_evt,
  input wire logic i_reset_evt,
  input wire logic [8:0] i_load_current,
  // Read answer
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  // Regulator and system controls
  output logic o_buck0_run,
  output logic o_buck0_discharge,
  output logic o_buck0_forced_pwm,
  output logic o_buck0_forced_multiphase,
  output logic o_soft_reset,
  // Copies of stored configuration
  output logic [7:0] o_pg_cfg_a,
  output logic [7:0] o_pg_cfg_b,
  output logic o_load_sel
);

  // Write decode helper used for every writable register
  function automatic logic wr_hit(input logic stb, input logic [7:0] a, input logic [7:0] ofs);
    wr_hit = stb && (a == ofs);
  endfunction

  // Flag update: write-one clears, a new event wins over the clear
  // so an event that lands during a clear is never lost
  function automatic pmcrb_byte_t flag_next(input pmcrb_byte_t cur, input pmcrb_byte_t evt,
                                            input logic clr, input pmcrb_byte_t wd);
    flag_next = (cur & ~(clr ? wd : 8'h00)) | evt;
  endfunction

  // Stored registers and their next values
  pmcrb_byte_t first_buck_control;
  pmcrb_byte_t next_first_buck_control;
  pmcrb_byte_t power_good_config_a;
  pmcrb_byte_t next_power_good_config_a;
  pmcrb_byte_t power_good_config_b;
  pmcrb_byte_t next_power_good_config_b;
  pmcrb_byte_t top_interrupt_flags_a;
  pmcrb_byte_t next_top_interrupt_flags_a;
  pmcrb_byte_t top_interrupt_flags_b;
  pmcrb_byte_t next_top_interrupt_flags_b;
  pmcrb_byte_t switcher_interrupt_flags;
  pmcrb_byte_t next_switcher_interrupt_flags;
  pmcrb_byte_t linear_interrupt_flags;
  pmcrb_byte_t next_linear_interrupt_flags;
  pmcrb_byte_t top_interrupt_mask_a;
  pmcrb_byte_t next_top_interrupt_mask_a;
  pmcrb_byte_t top_interrupt_mask_b;
  pmcrb_byte_t next_top_interrupt_mask_b;
  pmcrb_byte_t switcher_interrupt_mask;
  pmcrb_byte_t next_switcher_interrupt_mask;
  pmcrb_byte_t linear_interrupt_mask;
  pmcrb_byte_t next_linear_interrupt_mask;
  logic load_measure_select;
  logic next_load_measure_select;
  logic soft_reset_pulse;
  logic next_soft_reset_pulse;

  // First buck control next value: only the five defined bits are kept
  // Pin gating and enable are combined later in the output logic
  always_comb begin
    next_first_buck_control = first_buck_control;
    if (wr_hit(i_wr_stb, i_addr, `PMCRB_OFS_BUCK0_CTRL)) begin
      next_first_buck_control = i_wdata & `PMCRB_BUCK0_WMASK; // Reserved bits stay zero
    end
  end

  // First buck control register; bits 7:5 always read back zero
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      first_buck_control <= `PMCRB_RST_BUCK0_CTRL; // Discharge bit set at reset
    end else begin
      first_buck_control <= next_first_buck_control;
    end
  end

  // Power-good configuration next values, stored whole
  always_comb begin
    next_power_good_config_a = power_good_config_a;
    next_power_good_config_b = power_good_config_b;
    if (wr_hit(i_wr_stb, i_addr, `PMCRB_OFS_PG_CFG_A)) begin
      next_power_good_config_a = i_wdata;
    end
    if (wr_hit(i_wr_stb, i_addr, `PMCRB_OFS_PG_CFG_B)) begin
      next_power_good_config_b = i_wdata;
    end
  end

  // Power-good configuration registers
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      power_good_config_a <= `PMCRB_RST_ZERO;
      power_good_config_b <= `PMCRB_RST_ZERO;
    end else begin
      power_good_config_a <= next_power_good_config_a;
      power_good_config_b <= next_power_good_config_b;
    end
  end

  // Interrupt mask next values; masks are only stored, no interrupt is formed here
  always_comb begin
    next_top_interrupt_mask_a = top_interrupt_mask_a;
    next_top_interrupt_mask_b = top_interrupt_mask_b;
    next_switcher_interrupt_mask = switcher_interrupt_mask;
    next_linear_interrupt_mask = linear_interrupt_mask;
    if (wr_hit(i_wr_stb, i_addr, `PMCRB_OFS_MASK_TOP_A)) begin
      next_top_interrupt_mask_a = i_wdata;
    end
    if (wr_hit(i_wr_stb, i_addr, `PMCRB_OFS_MASK_TOP_B)) begin
      next_top_interrupt_mask_b = i_wdata;
    end
    if (wr_hit(i_wr_stb, i_addr, `PMCRB_OFS_MASK_SW)) begin
      next_switcher_interrupt_mask = i_wdata;
    end
    if (wr_hit(i_wr_stb, i_addr, `PMCRB_OFS_MASK_LIN)) begin
      next_linear_interrupt_mask = i_wdata;
    end
  end

  // Interrupt mask registers
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      top_interrupt_mask_a <= `PMCRB_RST_ZERO;
      top_interrupt_mask_b <= `PMCRB_RST_ZERO;
      switcher_interrupt_mask <= `PMCRB_RST_ZERO;
      linear_interrupt_mask <= `PMCRB_RST_ZERO;
    end else begin
      top_interrupt_mask_a <= next_top_interrupt_mask_a;
      top_interrupt_mask_b <= next_top_interrupt_mask_b;
      switcher_interrupt_mask <= next_switcher_interrupt_mask;
      linear_interrupt_mask <= next_linear_interrupt_mask;
    end
  end

  // Load measurement select and soft reset request next values
  // The soft reset request lasts one cycle, so its register reads back zero
  always_comb begin
    next_load_measure_select = load_measure_select;
    next_soft_reset_pulse = 1'b0;
    if (wr_hit(i_wr_stb, i_addr, `PMCRB_OFS_LOAD_SEL)) begin
      next_load_measure_select = i_wdata[0];
    end
    if (wr_hit(i_wr_stb, i_addr, `PMCRB_OFS_SOFT_RESET)) begin
      next_soft_reset_pulse = i_wdata[0]; // Self-clearing soft reset request
    end
  end

  // Load measurement select and soft reset request registers
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      load_measure_select <= 1'b0;
      soft_reset_pulse <= 1'b0;
    end else begin
      load_measure_select <= next_load_measure_select;
      soft_reset_pulse <= next_soft_reset_pulse;
    end
  end

  // Top level sticky flags, write one to clear, set beats clear
  always_comb begin
    next_top_interrupt_flags_a = flag_next(top_interrupt_flags_a, i_top_evt,
                                           wr_hit(i_wr_stb, i_addr, `PMCRB_OFS_INT_TOP_A), i_wdata);
    next_top_interrupt_flags_b = flag_next(top_interrupt_flags_b, {7'h00, i_reset_evt},
                                           wr_hit(i_wr_stb, i_addr, `PMCRB_OFS_INT_TOP_B), i_wdata);
  end

  // Top level flag registers
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      top_interrupt_flags_a <= `PMCRB_RST_ZERO;
      top_interrupt_flags_b <= `PMCRB_RST_ZERO;
    end else begin
      top_interrupt_flags_a <= next_top_interrupt_flags_a;
      top_interrupt_flags_b <= next_top_interrupt_flags_b;
    end
  end

  // Regulator sticky flags; reserved positions follow event inputs held low
  always_comb begin
    next_switcher_interrupt_flags = flag_next(switcher_interrupt_flags, i_sw_evt,
                                              wr_hit(i_wr_stb, i_addr, `PMCRB_OFS_INT_SW), i_wdata);
    next_linear_interrupt_flags = flag_next(linear_interrupt_flags, i_lin_evt,
                                            wr_hit(i_wr_stb, i_addr, `PMCRB_OFS_INT_LIN), i_wdata);
  end

  // Regulator flag registers
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      switcher_interrupt_flags <= `PMCRB_RST_ZERO;
      linear_interrupt_flags <= `PMCRB_RST_ZERO;
    end else begin
      switcher_interrupt_flags <= next_switcher_interrupt_flags;
      linear_interrupt_flags <= next_linear_interrupt_flags;
    end
  end

  // Regulator control outputs derived from the first buck control register
  // Built from next values so a control write shows on the outputs at the edge that takes it
  logic next_buck0_run;
  logic next_buck0_discharge;
  logic next_buck0_forced_pwm;
  logic next_buck0_forced_multiphase;
  always_comb begin
    next_buck0_run = next_first_buck_control[`PMCRB_BIT_ENABLE] &&
                     (!next_first_buck_control[`PMCRB_BIT_PIN_GATE] || i_en_pin);
    next_buck0_discharge = next_first_buck_control[`PMCRB_BIT_DISCHARGE] && !next_buck0_run;
    next_buck0_forced_pwm = next_first_buck_control[`PMCRB_BIT_FPWM];
    next_buck0_forced_multiphase = next_first_buck_control[`PMCRB_BIT_MULTIPHASE];
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_buck0_run <= 1'b0;
      o_buck0_discharge <= 1'b1;
      o_buck0_forced_pwm <= 1'b0;
      o_buck0_forced_multiphase <= 1'b0;
      o_soft_reset <= 1'b0;
      o_pg_cfg_a <= `PMCRB_RST_ZERO;
      o_pg_cfg_b <= `PMCRB_RST_ZERO;
      o_load_sel <= 1'b0;
    end else begin
      o_buck0_run <= next_buck0_run;
      o_buck0_discharge <= next_buck0_discharge;
      o_buck0_forced_pwm <= next_buck0_forced_pwm;
      o_buck0_forced_multiphase <= next_buck0_forced_multiphase;
      o_soft_reset <= next_soft_reset_pulse;
      o_pg_cfg_a <= next_power_good_config_a;
      o_pg_cfg_b <= next_power_good_config_b;
      o_load_sel <= next_load_measure_select;
    end
  end

  // Read multiplexer, unmapped offsets read zero
  // Status, fault and load levels pass straight through; the two load bytes are not latched as a pair
  pmcrb_byte_t next_rdata;
  always_comb begin
    unique case (i_addr)
      `PMCRB_OFS_PART_ID: next_rdata = {PART_ID, `PMCRB_PART_ID_LOW};
      `PMCRB_OFS_NVM_VER: next_rdata = NVM_VERSION;
      `PMCRB_OFS_BUCK0_CTRL: next_rdata = first_buck_control;
      `PMCRB_OFS_PG_CFG_A: next_rdata = power_good_config_a;
      `PMCRB_OFS_PG_CFG_B: next_rdata = power_good_config_b;
      `PMCRB_OFS_POWER_GOOD_FAULT_FLAGS: next_rdata = {4'h0, i_power_good_fault_flags};
      `PMCRB_OFS_SOFT_RESET: next_rdata = `PMCRB_RD_ZERO;
      `PMCRB_OFS_INT_TOP_A: next_rdata = top_interrupt_flags_a;
      `PMCRB_OFS_INT_TOP_B: next_rdata = top_interrupt_flags_b;
      `PMCRB_OFS_INT_SW: next_rdata = switcher_interrupt_flags;
      `PMCRB_OFS_INT_LIN: next_rdata = linear_interrupt_flags;
      `PMCRB_OFS_STAT_TOP: next_rdata = i_top_stat;
      `PMCRB_OFS_STAT_SW: next_rdata = i_sw_stat;
      `PMCRB_OFS_STAT_LIN: next_rdata = i_lin_stat;
      `PMCRB_OFS_MASK_TOP_A: next_rdata = top_interrupt_mask_a;
      `PMCRB_OFS_MASK_TOP_B: next_rdata = top_interrupt_mask_b;
      `PMCRB_OFS_MASK_SW: next_rdata = switcher_interrupt_mask;
      `PMCRB_OFS_MASK_LIN: next_rdata = linear_interrupt_mask;
      `PMCRB_OFS_LOAD_SEL: next_rdata = {7'h00, load_measure_select};
      `PMCRB_OFS_LOAD_HIGH: next_rdata = {7'h00, i_load_current[8]};
      `PMCRB_OFS_LOAD_LOW: next_rdata = i_load_current[7:0];
      default: next_rdata = `PMCRB_RD_ZERO;
    endcase
  end

  // Read data register, held between reads
  // The valid flag marks the single cycle after each read strobe
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= `PMCRB_RD_ZERO;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= i_rd_stb;
      if (i_rd_stb) begin
        o_rdata <= next_rdata;
      end
    end
  end

endmodule // pmcrb_regbank

// >>> pmcrb_regbank_properties.sv
/* Port checker for the control register bank.
   Assumes binding onto pmcrb_regbank with matching parameters. */
`timescale 1ns/1ps
module pmcrb_regbank_properties
  import pmcrb_pkg::*;
#(
  parameter pmcrb_part_t PART_ID = 2'h1,
  parameter pmcrb_byte_t NVM_VERSION = 8'h5A
) (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_wr_stb,
  input wire logic i_rd_stb,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_en_pin,
  input wire logic [7:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic o_buck0_run,
  input wire logic o_buck0_discharge,
  input wire logic o_buck0_forced_pwm,
  input wire logic o_buck0_forced_multiphase
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  // Control register write, and a gated enable while the pin stays low
  sequence s_ctl_wr;
    i_wr_stb && i_addr == 8'h02;
  endsequence
  sequence s_pin_low_gated;
    !i_en_pin ##1 s_ctl_wr ##0 (i_wdata[1:0] == 2'h3 && !i_en_pin);
  endsequence
  a_read_answer: assert property (i_rd_stb |=> o_rvalid) else $error("read not answered");
  a_answer_cause: assert property (o_rvalid |-> $past(i_rd_stb)) else $error("answer without read");
  a_fpwm_write: assert property (s_ctl_wr |=> o_buck0_forced_pwm == $past(i_wdata[3]))
    else $error("forced pwm wrong");
  a_phase_write: assert property (s_ctl_wr |=> o_buck0_forced_multiphase == $past(i_wdata[4]))
    else $error("phase mode wrong");
  a_run_enable: assert property (s_ctl_wr ##0 i_wdata[1:0] == 2'h1 |=> o_buck0_run)
    else $error("regulator not run");
  a_run_off: assert property (s_ctl_wr ##0 !i_wdata[0] |=> !o_buck0_run)
    else $error("regulator runs while off");
  a_pin_gate: assert property (s_pin_low_gated |=> !o_buck0_run) else $error("pin gate ignored");
  a_discharge_idle: assert property (s_ctl_wr ##0 i_wdata[2:0] == 3'h4 |=> o_buck0_discharge && !o_buck0_run)
    else $error("discharge not applied");
  a_part_id_read: assert property (i_rd_stb && i_addr == 8'h00 |=> o_rdata == {PART_ID, 6'h00})
    else $error("part id wrong");
  a_nvm_read: assert property (i_rd_stb && i_addr == 8'h01 |=> o_rdata == NVM_VERSION)
    else $error("version code wrong");
endmodule // pmcrb_regbank_properties

bind pmcrb_regbank pmcrb_regbank_properties #(.PART_ID(PART_ID), .NVM_VERSION(NVM_VERSION)) u_props (
  .i_sys_clk, .i_arst_n, .i_wr_stb, .i_rd_stb, .i_addr, .i_wdata, .i_en_pin, .o_rdata, .o_rvalid,
  .o_buck0_run, .o_buck0_discharge, .o_buck0_forced_pwm, .o_buck0_forced_multiphase);

// >>> pmcrb_host_model.sv
/* Host model driving the byte register port.
   Assumes a free-running i_sys_clk shared with the bank. */
`timescale 1ns/1ps
module pmcrb_host_model (
  input wire logic i_sys_clk,
  input wire logic [7:0] i_rdata,
  input wire logic i_rvalid,
  output logic o_wr_stb,
  output logic o_rd_stb,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata
);
  // Idle port
  initial begin
    o_wr_stb = 1'b0;
    o_rd_stb = 1'b0;
    o_addr = 8'hFF;
    o_wdata = 8'hFF;
  end
  // One-cycle write; callers write reserved bits as zero
  task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    o_wr_stb <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_sys_clk);
    o_wr_stb <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
  // One-cycle read; answer taken at the edge after the request
  task automatic read_byte(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge i_sys_clk);
    o_rd_stb <= 1'b1;
    o_addr <= a;
    @(posedge i_sys_clk);
    o_rd_stb <= 1'b0;
    o_addr <= ~a;
    @(posedge i_sys_clk);
    ok = i_rvalid;
    d = i_rdata;
  endtask
endmodule // pmcrb_host_model

// >>> pmic_control_register_bank_tb.sv
/* Self-checking bench for the control register bank.
   Assumes the host model and checker files compile alongside. */
`timescale 1ns/1ps
module pmic_control_register_bank_tb;
  import pmcrb_pkg::*;
  localparam pmcrb_part_t PART = 2'h2; // Arbitrary variant code
  localparam pmcrb_byte_t NVM = 8'hC3; // Arbitrary version code
  logic i_sys_clk = 1'b0, i_arst_n = 1'b0, i_wr_stb, i_rd_stb, i_en_pin = 1'b0, i_reset_evt = 1'b0;
  logic [7:0] i_addr, i_wdata, i_top_stat = 8'hA5, i_sw_stat = 8'h3C, i_lin_stat = 8'h81;
  logic [7:0] i_top_evt = 8'h00, i_sw_evt = 8'h00, i_lin_evt = 8'h00, o_rdata, o_pg_cfg_a, o_pg_cfg_b, v;
  logic [3:0] i_power_good_fault_flags = 4'h9;
  logic [8:0] i_load_current = 9'h1C3;
  logic o_rvalid, o_buck0_run, o_buck0_discharge, o_buck0_forced_pwm, o_buck0_forced_multiphase;
  logic o_soft_reset, o_load_sel;
  int n_errors = 0, comparisons = 0;
  always #10 i_sys_clk = ~i_sys_clk;
  pmcrb_regbank #(.PART_ID(PART), .NVM_VERSION(NVM)) u_dut (.i_sys_clk, .i_arst_n, .i_wr_stb, .i_rd_stb,
    .i_addr, .i_wdata, .i_en_pin, .i_power_good_fault_flags, .i_top_stat, .i_sw_stat, .i_lin_stat, .i_top_evt, .i_sw_evt,
    .i_lin_evt, .i_reset_evt, .i_load_current, .o_rdata, .o_rvalid, .o_buck0_run, .o_buck0_discharge,
    .o_buck0_forced_pwm, .o_buck0_forced_multiphase, .o_soft_reset, .o_pg_cfg_a, .o_pg_cfg_b, .o_load_sel);
  pmcrb_host_model u_host (.i_sys_clk, .i_rdata(o_rdata), .i_rvalid(o_rvalid), .o_wr_stb(i_wr_stb),
    .o_rd_stb(i_rd_stb), .o_addr(i_addr), .o_wdata(i_wdata));
  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Read through the host and compare valid and data
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    u_host.read_byte(a, d, ok);
    check({7'h0, ok}, 8'h01);
    check(d, exp);
  endtask
  // Settled regulator outputs: run, discharge
  task automatic out_chk(input logic run, input logic dis);
    @(negedge i_sys_clk);
    check({7'h0, o_buck0_run}, {7'h0, run});
    check({7'h0, o_buck0_discharge}, {7'h0, dis});
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (2000) @(posedge i_sys_clk);
    n_errors++;
    wrap_up();
  end
  // Test sequence
  initial begin
    repeat (5) @(posedge i_sys_clk);
    out_chk(1'b0, 1'b1);
    @(posedge i_sys_clk);
    i_arst_n <= 1'b1;
    rd_chk(8'h00, {PART, 6'h00});
    rd_chk(8'h01, NVM);
    rd_chk(8'h02, 8'h04);
    u_host.write_byte(8'h00, 8'hFF);
    u_host.write_byte(8'h01, 8'h00);
    rd_chk(8'h00, {PART, 6'h00});
    rd_chk(8'h01, NVM);
    $display("test identification done");
    for (int i = 0; i < 4; i++) begin
      v = {3'h0, 2'(i), 3'h4};
      u_host.write_byte(8'h02, v);
      out_chk(1'b0, 1'b1);
      check({7'h0, o_buck0_forced_pwm}, {7'h0, v[3]});
      check({7'h0, o_buck0_forced_multiphase}, {7'h0, v[4]});
      rd_chk(8'h02, v);
    end
    $display("test mode bits done");
    u_host.write_byte(8'h02, 8'h07);
    out_chk(1'b0, 1'b1);
    @(posedge i_sys_clk);
    i_en_pin <= 1'b1;
    @(posedge i_sys_clk);
    out_chk(1'b1, 1'b0);
    u_host.write_byte(8'h02, 8'h01);
    out_chk(1'b1, 1'b0);
    u_host.write_byte(8'h02, 8'h00);
    out_chk(1'b0, 1'b0);
    $display("test enable done");
    rd_chk(8'h1D, 8'hA5);
    rd_chk(8'h1E, 8'h3C);
    rd_chk(8'h1F, 8'h81);
    rd_chk(8'h17, 8'h09);
    rd_chk(8'h25, 8'h01);
    rd_chk(8'h26, 8'hC3);
    rd_chk(8'h30, 8'h00);
    @(posedge i_sys_clk);
    i_sw_evt <= 8'h12;
    i_top_evt <= 8'h81;
    i_reset_evt <= 1'b1;
    @(posedge i_sys_clk);
    i_sw_evt <= 8'h00;
    i_top_evt <= 8'h00;
    i_reset_evt <= 1'b0;
    rd_chk(8'h1B, 8'h12);
    rd_chk(8'h19, 8'h81);
    rd_chk(8'h1A, 8'h01);
    u_host.write_byte(8'h1B, 8'h02);
    rd_chk(8'h1B, 8'h10);
    u_host.write_byte(8'h1A, 8'h01);
    rd_chk(8'h1A, 8'h00);
    // Event and clear sampled at the same edge: the event must survive
    fork
      u_host.write_byte(8'h1C, 8'h01);
      begin
        @(posedge i_sys_clk);
        i_lin_evt <= 8'h01;
        @(posedge i_sys_clk);
        i_lin_evt <= 8'h00;
      end
    join
    rd_chk(8'h1C, 8'h01);
    u_host.write_byte(8'h1C, 8'h01);
    rd_chk(8'h1C, 8'h00);
    $display("test status done");
    u_host.write_byte(8'h15, 8'hA5);
    u_host.write_byte(8'h16, 8'h07);
    u_host.write_byte(8'h24, 8'h01);
    @(negedge i_sys_clk);
    check(o_pg_cfg_a, 8'hA5);
    check(o_pg_cfg_b, 8'h07);
    check({7'h0, o_load_sel}, 8'h01);
    rd_chk(8'h15, 8'hA5);
    rd_chk(8'h16, 8'h07);
    rd_chk(8'h24, 8'h01);
    for (int k = 0; k < 4; k++) begin
      v = 8'h90 | 8'(k);
      u_host.write_byte(8'h20 + 8'(k), v);
      rd_chk(8'h20 + 8'(k), v);
    end
    u_host.write_byte(8'h18, 8'h01);
    @(negedge i_sys_clk);
    check({7'h0, o_soft_reset}, 8'h01);
    @(negedge i_sys_clk);
    check({7'h0, o_soft_reset}, 8'h00);
    rd_chk(8'h18, 8'h00);
    $display("test configuration done");
    @(posedge i_sys_clk);
    i_arst_n <= 1'b0;
    @(negedge i_sys_clk);
    check(o_pg_cfg_a, 8'h00);
    check({7'h0, o_load_sel}, 8'h00);
    @(posedge i_sys_clk);
    i_arst_n <= 1'b1;
    rd_chk(8'h02, 8'h04);
    rd_chk(8'h19, 8'h00);
    out_chk(1'b0, 1'b1);
    $display("test mid-run reset done");
    wrap_up();
  end
endmodule // pmic_control_register_bank_tb
